//--- design/swm_master.sv
`timescale 1ns/1ps
`include "swm_consts.svh"

// Contract
// R1: all bits travel least significant bit first, both directions.
// R2: master waits power-up quiet time before any bus traffic.
// R3: slave may emit presence pulses alone during power-up quiet time.
// R4: spontaneous power-up presence ends within 1.5 ms.
// R5: bus idles high; master keeps it released during any pause.
// R6: slave tells slots from resets by how long the line stays low.
// R7: both parties drive only open-drain, wired-AND.
// R8: slave never starts a slot; answers master falling edges only.
// R9: master order: initialization, ROM command byte, then data bits.
// R10: initialization is master reset pulse then slave presence pulse.
// R11: exactly one one-byte ROM command follows presence.
// R12: code 33h returns family byte, 48-bit serial, then CRC byte.
// R13: read command only valid with a single slave on the bus.
// R14: code F0h handles each number bit as a triplet of slots.
// R15: searching slave sends true bit, then its complement.
// R16: third slot is master bit; mismatching slave drops out.
// R17: both read slots zero means both branches exist; master picks.
// R18: one search pass yields one number; more passes find others.
// R19: number is 8-bit family, 48-bit serial and 8-bit CRC.
// R20: standard speed up to 15.4 kbps, fast mode up to 125 kbps.
// R21: code 3Ch sets fast-speed flag; fast timing until long reset.
// R22: reset of 480 us clears fast flag; 80 us or less keeps it. Slave model clears it after 1900 cycles (76 us) of low.
// R23: slave waits presence high delay, then pulls low for presence.
// R24: slave answers 0 by timed low, answers 1 by not driving.
// R25: unknown command: slave stays silent until the next reset.
module swm_master #(
	parameter logic [15:0] PWRUP_CYC    = 16'(swm_pkg::cyc_up(`SWM_PWRUP_NS)),
	parameter logic [15:0] PWRUP_LP_CYC = 16'(swm_pkg::cyc_up(`SWM_PWRUP_LP_NS)),
	parameter logic [15:0] RSTL_STD_CYC = 16'(swm_pkg::cyc_up(`SWM_RSTL_STD_NS)),
	parameter logic [15:0] RSTH_STD_CYC = 16'(swm_pkg::cyc_up(`SWM_RSTH_STD_NS)),
	parameter bit          LINE_POWERED = 1'b0,
	parameter int          FIFO_DEPTH   = `SWM_FIFO_DEPTH
) (
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic            cmd_valid,
	input  wire swm_pkg::swm_op_t cmd_op,
	input  wire logic            cmd_long_rst,
	input  wire logic [63:0]     search_dir,
	output logic                 cmd_ready,
	output logic                 done,
	output logic                 presence,
	output logic                 search_fail,
	output logic                 fast_speed_flag,
	input  wire logic            io_in,
	output logic                 io_out,
	output logic                 io_oe,
	output logic [7:0]           rx_data,
	output logic                 rx_valid,
	input  wire logic            rx_ready
);
	// =================================================================
	// timing in cycles
	localparam logic [15:0] C_RSTL_OD  = 16'(swm_pkg::cyc_up(`SWM_RSTL_OD_NS));
	localparam logic [15:0] C_RSTH_OD  = 16'(swm_pkg::cyc_up(`SWM_RSTH_OD_NS));
	localparam logic [15:0] C_MSP_STD  = 16'(swm_pkg::cyc_up(`SWM_MSP_STD_NS));
	localparam logic [15:0] C_MSP_OD   = 16'(swm_pkg::cyc_up(`SWM_MSP_OD_NS));
	localparam logic [15:0] C_END_STD  =
		16'(swm_pkg::cyc_up(`SWM_SLOT_STD_NS + `SWM_REC_STD_NS));
	localparam logic [15:0] C_END_OD   =
		16'(swm_pkg::cyc_up(`SWM_SLOT_OD_NS + `SWM_REC_OD_NS));
	localparam logic [15:0] C_W0_STD   = 16'(swm_pkg::cyc_up(`SWM_W0L_STD_NS));
	localparam logic [15:0] C_W0_OD    = 16'(swm_pkg::cyc_up(`SWM_W0L_OD_NS));
	localparam logic [15:0] C_W1_STD   = 16'(swm_pkg::cyc_up(`SWM_W1L_STD_NS));
	localparam logic [15:0] C_W1_OD    = 16'(swm_pkg::cyc_up(`SWM_W1L_OD_NS));
	localparam logic [15:0] C_MSR_STD  = 16'(swm_pkg::cyc_dn(`SWM_MSR_STD_NS));
	localparam logic [15:0] C_MSR_OD   = 16'(swm_pkg::cyc_dn(`SWM_MSR_OD_NS));
	localparam logic [15:0] C_PWR      = LINE_POWERED ? PWRUP_LP_CYC : PWRUP_CYC;
	localparam int          A_W1_MAX   = 160;

	swm_pkg::swm_state_t st_q, st_d;
	swm_pkg::swm_phase_t ph_q, ph_d;
	swm_pkg::swm_op_t    op_q, op_d;
	logic [15:0]         cnt_q, cnt_d;
	logic [5:0]          idx_q, idx_d;
	logic [7:0]          sh_q, sh_d;
	logic [63:0]         rom_q, rom_d;
	logic [63:0]         dir_q, dir_d;
	logic                bit_q, bit_d;
	logic                tb_q, tb_d;
	logic                smp_q, smp_d;
	logic                long_q, long_d;
	logic                fast_q, fast_d;
	logic                pres_q, pres_d;
	logic                fail_q, fail_d;
	logic                done_q, done_d;
	logic                rdy_q, rdy_d;
	logic                oe_q, oe_d;
	logic                io_out_q;
	logic                s1_q, s2_q, s3_q, line_q, line_d;
	logic                push, fifo_rdy, fin, nb, rst_long;
	logic [7:0]          pdata;
	logic [15:0]         t_rstl, t_rsth, t_msp, t_lo, t_msr, t_end;

	// speed-dependent time pick
	function automatic logic [15:0] tsel(input logic f, input logic [15:0] s,
		input logic [15:0] o);
		return f ? o : s;
	endfunction : tsel

	// ROM command byte for an operation
	function automatic logic [7:0] cmd_code(input swm_pkg::swm_op_t op);
		unique case (op)
			swm_pkg::OP_READ:   return `SWM_CMD_READ;
			swm_pkg::OP_SEARCH: return `SWM_CMD_SEARCH;
			default:            return `SWM_CMD_OD_SKIP;
		endcase
	endfunction : cmd_code

	// =================================================================
	// pin input synchroniser, change taken when stages 2 and 3 agree
	always_comb
	begin
		line_d = (s2_q == s3_q) ? s3_q : line_q;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s1_q   <= 1'b1;
			s2_q   <= 1'b1;
			s3_q   <= 1'b1;
			line_q <= 1'b1;
		end
		else
		begin
			s1_q   <= io_in;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			line_q <= line_d;
		end
	end

	// =================================================================
	// time selection by speed and reset length
	always_comb
	begin
		rst_long = long_q || !fast_q; // R22
		t_rstl   = rst_long ? RSTL_STD_CYC : C_RSTL_OD; // R6
		t_rsth   = tsel(fast_q, RSTH_STD_CYC, C_RSTH_OD);
		t_msp    = tsel(fast_q, C_MSP_STD, C_MSP_OD);
		t_lo     = bit_q ? tsel(fast_q, C_W1_STD, C_W1_OD)
			: tsel(fast_q, C_W0_STD, C_W0_OD);
		t_msr    = tsel(fast_q, C_MSR_STD, C_MSR_OD);
		t_end    = tsel(fast_q, C_END_STD, C_END_OD); // R20
	end

	// =================================================================
	// sequencer: power-up, reset/presence, command, data slots
	always_comb
	begin
		st_d   = st_q;
		ph_d   = ph_q;
		op_d   = op_q;
		cnt_d  = cnt_q + 16'h0001;
		idx_d  = idx_q;
		sh_d   = sh_q;
		rom_d  = rom_q;
		dir_d  = dir_q;
		bit_d  = bit_q;
		tb_d   = tb_q;
		smp_d  = smp_q;
		long_d = long_q;
		fast_d = fast_q;
		pres_d = pres_q;
		fail_d = fail_q;
		rdy_d  = rdy_q;
		oe_d   = oe_q;
		done_d = 1'b0;
		push   = 1'b0;
		fin    = 1'b0;
		nb     = 1'b0;
		pdata  = rom_q[63:56];
		unique case (st_q)
			swm_pkg::ST_PWR:
			begin
				// stay released; stray presence pulses are ignored
				if (cnt_q == C_PWR - 16'h0001) // R2 R3 R4
				begin
					st_d  = swm_pkg::ST_IDLE;
					rdy_d = 1'b1;
				end
			end
			swm_pkg::ST_IDLE:
			begin
				cnt_d = '0;
				if (cmd_valid) // R9
				begin
					op_d   = cmd_op;
					long_d = cmd_long_rst;
					dir_d  = search_dir;
					rdy_d  = 1'b0;
					pres_d = 1'b0;
					fail_d = 1'b0;
					oe_d   = 1'b1; // R10
					st_d   = swm_pkg::ST_RLOW;
				end
			end
			swm_pkg::ST_RLOW:
			begin
				if (cnt_q == t_rstl - 16'h0001)
				begin
					oe_d  = 1'b0;
					cnt_d = '0;
					st_d  = swm_pkg::ST_RHIGH;
					if (rst_long)
						fast_d = 1'b0; // R22
				end
			end
			swm_pkg::ST_RHIGH:
			begin
				if (cnt_q == t_msp - 16'h0001)
					pres_d = !line_q; // R10 R23
				if (cnt_q == t_rsth - 16'h0001)
				begin
					if (op_q == swm_pkg::OP_RESET || !pres_q)
						fin = 1'b1;
					else
					begin
						// exactly one valid command byte follows
						ph_d  = swm_pkg::PH_CMD; // R11 R25
						sh_d  = cmd_code(op_q);
						bit_d = sh_d[0]; // R1
						idx_d = '0;
						st_d  = swm_pkg::ST_WAIT;
					end
				end
			end
			swm_pkg::ST_WAIT:
			begin
				// pushing slots wait for fifo room
				cnt_d = '0;
				if (fifo_rdy || !(ph_q == swm_pkg::PH_READ || ph_q == swm_pkg::PH_CMPL))
				begin
					oe_d = 1'b1; // R7
					st_d = swm_pkg::ST_LOW;
				end
			end
			swm_pkg::ST_LOW:
			begin
				if (cnt_q == t_lo - 16'h0001)
				begin
					oe_d = 1'b0; // R24
					st_d = swm_pkg::ST_HIGH;
				end
			end
			swm_pkg::ST_HIGH:
			begin
				if (cnt_q == t_msr - 16'h0001)
					smp_d = line_q; // R24
				if (cnt_q == t_end - 16'h0001)
				begin
					st_d = swm_pkg::ST_WAIT;
					unique case (ph_q)
						swm_pkg::PH_CMD:
						begin
							if (idx_q == `SWM_CMD_LAST)
							begin
								idx_d = '0;
								bit_d = 1'b1;
								if (op_q == swm_pkg::OP_READ)
									ph_d = swm_pkg::PH_READ; // R12 R13
								else if (op_q == swm_pkg::OP_SEARCH)
									ph_d = swm_pkg::PH_TRUE; // R14
								else
								begin
									fast_d = 1'b1; // R21
									fin    = 1'b1;
								end
							end
							else
							begin
								sh_d  = sh_q >> 1; // R1
								bit_d = sh_q[1];
								idx_d = idx_q + 6'h01;
							end
						end
						swm_pkg::PH_READ:
						begin
							// family, serial, crc arrive in that order
							rom_d = {smp_q, rom_q[63:1]}; // R1 R12 R19
							pdata = rom_d[63:56];
							push  = (idx_q[2:0] == `SWM_BYTE_LAST);
							if (idx_q == `SWM_BIT_LAST)
								fin = 1'b1;
							else
								idx_d = idx_q + 6'h01;
						end
						swm_pkg::PH_TRUE:
						begin
							tb_d = smp_q; // R15
							ph_d = swm_pkg::PH_CMPL;
						end
						swm_pkg::PH_CMPL:
						begin
							if (tb_q && smp_q)
							begin
								fail_d = 1'b1; // R16
								fin    = 1'b1;
							end
							else
							begin
								// conflict: caller picks the branch
								nb    = (tb_q ^ smp_q) ? tb_q : dir_q[idx_q]; // R17
								bit_d = nb; // R16
								rom_d = {nb, rom_q[63:1]};
								pdata = rom_d[63:56];
								push  = (idx_q[2:0] == `SWM_BYTE_LAST);
								ph_d  = swm_pkg::PH_WR;
							end
						end
						swm_pkg::PH_WR:
						begin
							if (idx_q == `SWM_BIT_LAST)
								fin = 1'b1; // R18
							else
							begin
								idx_d = idx_q + 6'h01; // R14
								bit_d = 1'b1;
								ph_d  = swm_pkg::PH_TRUE;
							end
						end
					endcase
				end
			end
		endcase
		if (fin)
		begin
			// line stays released while idle
			done_d = 1'b1; // R5
			rdy_d  = 1'b1;
			oe_d   = 1'b0;
			st_d   = swm_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_q     <= swm_pkg::ST_PWR;
			ph_q     <= swm_pkg::PH_CMD;
			op_q     <= swm_pkg::OP_RESET;
			cnt_q    <= '0;
			idx_q    <= '0;
			sh_q     <= '0;
			rom_q    <= '0;
			dir_q    <= '0;
			bit_q    <= 1'b1;
			tb_q     <= 1'b0;
			smp_q    <= 1'b1;
			long_q   <= 1'b0;
			fast_q   <= 1'b0;
			pres_q   <= 1'b0;
			fail_q   <= 1'b0;
			done_q   <= 1'b0;
			rdy_q    <= 1'b0;
			oe_q     <= 1'b0;
			io_out_q <= 1'b0;
		end
		else
		begin
			st_q     <= st_d;
			ph_q     <= ph_d;
			op_q     <= op_d;
			cnt_q    <= cnt_d;
			idx_q    <= idx_d;
			sh_q     <= sh_d;
			rom_q    <= rom_d;
			dir_q    <= dir_d;
			bit_q    <= bit_d;
			tb_q     <= tb_d;
			smp_q    <= smp_d;
			long_q   <= long_d;
			fast_q   <= fast_d;
			pres_q   <= pres_d;
			fail_q   <= fail_d;
			done_q   <= done_d;
			rdy_q    <= rdy_d;
			oe_q     <= oe_d;
			io_out_q <= 1'b0; // R7
		end
	end

	// =================================================================
	// received number bytes toward the user
	swm_fifo #(
		.W     (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (push),
		.in_data   (pdata),
		.in_ready  (fifo_rdy),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready)
	);

	assign cmd_ready       = rdy_q;
	assign done            = done_q;
	assign presence        = pres_q;
	assign search_fail     = fail_q;
	assign fast_speed_flag = fast_q;
	assign io_out          = io_out_q;
	assign io_oe           = oe_q;

	// =================================================================
	// checks
	a_pwr_quiet: // R2
	assert property (@(posedge clock) disable iff (rst)
		st_q == swm_pkg::ST_PWR |-> !oe_q && !rdy_q)
	else $error("bus touched during power-up quiet time");

	a_idle_released: // R5
	assert property (@(posedge clock) disable iff (rst)
		st_q == swm_pkg::ST_IDLE |-> !oe_q && rdy_q)
	else $error("line driven while idle");

	a_open_drain: // R7
	assert property (@(posedge clock) disable iff (rst) !io_out_q)
	else $error("pin driven high");

	a_init_first: // R9
	assert property (@(posedge clock) disable iff (rst)
		st_q == swm_pkg::ST_IDLE && cmd_valid |=> st_q == swm_pkg::ST_RLOW && oe_q)
	else $error("command not opened by reset pulse");

	a_cmd_lsb_first: // R1
	assert property (@(posedge clock) disable iff (rst)
		st_q == swm_pkg::ST_WAIT && ph_q == swm_pkg::PH_CMD |-> bit_q == sh_q[0])
	else $error("command bit not lsb first");

	a_one_release: // R24
	assert property (@(posedge clock) disable iff (rst)
		$rose(oe_q) && st_q == swm_pkg::ST_LOW && bit_q |-> ##[1:A_W1_MAX] !oe_q)
	else $error("one or read slot held low too long");

	a_presence_wait: // R10
	assert property (@(posedge clock) disable iff (rst)
		st_q == swm_pkg::ST_RHIGH |-> !oe_q && cnt_q < t_rsth)
	else $error("presence window not released");

	a_fast_clear: // R22
	assert property (@(posedge clock) disable iff (rst)
		st_q == swm_pkg::ST_RLOW && rst_long ##1 st_q == swm_pkg::ST_RHIGH |-> !fast_q)
	else $error("long reset kept fast speed");

	a_od_set: // R21
	assert property (@(posedge clock) disable iff (rst)
		done_q && op_q == swm_pkg::OP_OD && pres_q |-> fast_q)
	else $error("fast flag not set after skip command");

	a_search_fail: // R16
	assert property (@(posedge clock) disable iff (rst)
		$rose(fail_q) |-> op_q == swm_pkg::OP_SEARCH && done_q)
	else $error("search failure outside a search");

	a_read_room: // R12
	assert property (@(posedge clock) disable iff (rst)
		st_q == swm_pkg::ST_LOW && $past(st_q) == swm_pkg::ST_WAIT
		&& ph_q == swm_pkg::PH_READ |-> $past(fifo_rdy))
	else $error("read slot started with full fifo");

endmodule : swm_master

//--- design/swm_consts.svh
`ifndef SWM_CONSTS_SVH
`define SWM_CONSTS_SVH

// =====================================================================
// clock
`define SWM_CLK_NS        40
// =====================================================================
// power-up quiet time, supplied and line-powered slaves
`define SWM_PWRUP_NS      1200000
`define SWM_PWRUP_LP_NS   2000000
// =====================================================================
// reset and presence timing, standard / fast speed
`define SWM_RSTL_STD_NS   480000
`define SWM_RSTL_OD_NS    70000
`define SWM_RSTH_STD_NS   480000
`define SWM_RSTH_OD_NS    48000
`define SWM_MSP_STD_NS    70000
`define SWM_MSP_OD_NS     8000
// =====================================================================
// bit slot timing, standard / fast speed
`define SWM_SLOT_STD_NS   65000
`define SWM_SLOT_OD_NS    10000
`define SWM_REC_STD_NS    5000
`define SWM_REC_OD_NS     2000
`define SWM_W0L_STD_NS    60000
`define SWM_W0L_OD_NS     8000
`define SWM_W1L_STD_NS    6000
`define SWM_W1L_OD_NS     1000
`define SWM_MSR_STD_NS    13000
`define SWM_MSR_OD_NS     1800
// =====================================================================
// command codes and framing
`define SWM_CMD_READ      8'h33
`define SWM_CMD_SEARCH    8'hF0
`define SWM_CMD_OD_SKIP   8'h3C
`define SWM_BIT_LAST      6'h3F
`define SWM_BYTE_LAST     3'h7
`define SWM_CMD_LAST      6'h07
`define SWM_CNT_W         16
`define SWM_FIFO_DEPTH    8

`endif

//--- design/swm_pkg.sv
`include "swm_consts.svh"

package swm_pkg;

	// =================================================================
	// host operations and sequencer states
	typedef enum logic [1:0] {OP_READ, OP_SEARCH, OP_OD, OP_RESET} swm_op_t;
	typedef enum logic [2:0] {ST_PWR, ST_IDLE, ST_RLOW, ST_RHIGH, ST_WAIT, ST_LOW,
		ST_HIGH} swm_state_t;
	typedef enum logic [2:0] {PH_CMD, PH_READ, PH_TRUE, PH_CMPL, PH_WR} swm_phase_t;

	// least time in whole cycles, rounded up
	function automatic int cyc_up(input int ns);
		return (ns + `SWM_CLK_NS - 1) / `SWM_CLK_NS;
	endfunction : cyc_up

	// longest time in whole cycles, rounded down, never below one
	function automatic int cyc_dn(input int ns);
		return (ns < `SWM_CLK_NS) ? 1 : ns / `SWM_CLK_NS;
	endfunction : cyc_dn

endpackage : swm_pkg

//--- design/swm_fifo.sv
`timescale 1ns/1ps

module swm_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          ov_q, ov_d;
	logic [W-1:0]  od_q, od_d;
	logic [CW:0]   occ;
	logic          push, pop;

	// pointer step with wrap for any depth
	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : nxt

	// =================================================================
	// occupancy, pointers and registered output stage
	always_comb
	begin
		occ      = {1'b0, cnt_q} + {{CW{1'b0}}, ov_q};
		in_ready = occ < (CW + 1)'(DEPTH);
		push     = in_valid && in_ready;
		pop      = (cnt_q != '0) && (!ov_q || out_ready);
		wp_d     = push ? nxt(wp_q) : wp_q;
		rp_d     = pop ? nxt(rp_q) : rp_q;
		cnt_d    = cnt_q + CW'(push) - CW'(pop);
		ov_d     = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
		od_d     = pop ? mem_q[rp_q] : od_q;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
			ov_q  <= 1'b0;
			od_q  <= '0;
		end
		else
		begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
			ov_q  <= ov_d;
			od_q  <= od_d;
		end
	end

	// storage has no reset
	always_ff @(posedge clock)
	begin
		if (push)
			mem_q[wp_q] <= in_data;
	end

	assign out_valid = ov_q;
	assign out_data  = od_q;

	a_fifo_full_honest:
	assert property (@(posedge clock) disable iff (rst) !in_ready |-> occ == (CW + 1)'(DEPTH))
	else $error("fifo refuses data while not full");

endmodule : swm_fifo

//--- bench/swm_slave_model.sv
`timescale 1ns/1ps

module swm_slave_model #(
	parameter logic [63:0] ROM      = 64'h0,
	parameter int          RST_MIN  = 1600,
	parameter int          LONG_RST = 1900
) (
	input  wire logic  clock,
	input  wire logic  rst,
	input  wire logic  enable,
	input  wire logic  io,
	output logic       oe,
	output logic [7:0] cmd_seen,
	output logic       fast_flag
);
	// =====================================================================
	// device state
	logic       drv, io_q, in_slot, snd;
	logic [1:0] mode, trip;
	logic [5:0] bcnt;
	logic [7:0] sh;
	int         low_cnt, cnt, pcnt, samp, pdh, pdl;

	// open-drain pull only, never drives high
	assign oe   = drv & enable;
	// true bit, complement in second search slot
	assign snd  = (mode == 2'd2 && trip == 2'd1) ? ~ROM[bcnt] : ROM[bcnt];
	assign samp = fast_flag ? 75 : 750;
	assign pdh  = fast_flag ? 50 : 375;
	assign pdl  = fast_flag ? 375 : 1500;

	// slot, reset and presence tracking
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			drv       <= 1'b0;
			io_q      <= 1'b1;
			in_slot   <= 1'b0;
			mode      <= 2'd3;
			trip      <= 2'd0;
			bcnt      <= 6'h00;
			sh        <= 8'h00;
			low_cnt   <= 0;
			cnt       <= 0;
			pcnt      <= 1800; // short spontaneous presence after power-up
			cmd_seen  <= 8'h00;
			fast_flag <= 1'b0;
		end
		else
		begin
			io_q <= io;
			if (!io && !drv)
				low_cnt <= low_cnt + 1;
			else if (io)
				low_cnt <= 0;
			if (pcnt != 0)
			begin
				// wait presence high delay, then pull low
				pcnt <= (pcnt > pdh + pdl) ? 0 : pcnt + 1;
				drv  <= (pcnt >= pdh && pcnt < pdh + pdl);
			end
			else if (io && !io_q && low_cnt >= RST_MIN)
			begin
				// long low is a reset, short low a slot
				pcnt <= 1;
				mode <= 2'd0;
				trip <= 2'd0;
				bcnt <= 6'h00;
				if (low_cnt >= LONG_RST)
					fast_flag <= 1'b0;
			end
			else if (!io && io_q && !drv)
			begin
				// slot starts only on a master falling edge
				in_slot <= 1'b1;
				cnt     <= 1;
				if ((mode == 2'd1 || (mode == 2'd2 && trip != 2'd2)) && !snd)
					drv <= 1'b1; // zero is a timed low, one is no drive
			end
			else if (in_slot)
			begin
				cnt <= cnt + 1;
				if (cnt == samp)
				begin
					drv     <= 1'b0;
					in_slot <= 1'b0;
					case (mode)
						2'd0:
						begin
							// command byte arrives least significant bit first
							sh   <= {io, sh[7:1]};
							bcnt <= bcnt + 6'h01;
							if (bcnt == 6'h07)
							begin
								cmd_seen <= {io, sh[7:1]};
								bcnt     <= 6'h00;
								mode     <= ({io, sh[7:1]} == 8'h33) ? 2'd1 :
									({io, sh[7:1]} == 8'hF0) ? 2'd2 : 2'd3;
								if ({io, sh[7:1]} == 8'h3C)
									fast_flag <= 1'b1;
							end
						end
						2'd1:
						begin
							bcnt <= bcnt + 6'h01;
							if (bcnt == 6'h3F)
								mode <= 2'd3;
						end
						2'd2:
						begin
							trip <= (trip == 2'd2) ? 2'd0 : trip + 2'd1;
							if (trip == 2'd2 && io != ROM[bcnt])
								mode <= 2'd3;
							else if (trip == 2'd2)
							begin
								bcnt <= bcnt + 6'h01;
								if (bcnt == 6'h3F)
									mode <= 2'd3;
							end
						end
						default: mode <= 2'd3;
					endcase
				end
			end
		end
	end

endmodule : swm_slave_model

//--- bench/swm_master_bench.sv
`timescale 1ns/1ps

module swm_master_bench;
	// =====================================================================
	// signals
	localparam logic [63:0] ROM_A = 64'hA1B2C3D4E5F60718; // arbitrary number
	localparam logic [63:0] ROM_B = 64'h21B2C3D4E5F6071C; // arbitrary number
	logic             clock, rst, cmd_valid, cmd_long_rst, rx_ready, en_a, en_b;
	swm_pkg::swm_op_t cmd_op;
	logic [63:0]      search_dir;
	logic             cmd_ready, done, presence, search_fail, fast_speed_flag;
	logic             io_out, io_oe, rx_valid, oe_a, oe_b, fast_a, fast_b;
	logic [7:0]       rx_data, cmd_a, cmd_b;
	wire logic        io_line;
	logic [7:0]       rxq[$];
	int               error_cnt, comparisons;

	// wired-AND line with pull-up
	assign io_line = ~(io_oe | oe_a | oe_b);

	// =====================================================================
	// design and two slave devices
	swm_master #(.PWRUP_CYC(16'h00C8), .RSTL_STD_CYC(16'h07D0), .RSTH_STD_CYC(16'h07D0)) dut (
		.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_long_rst(cmd_long_rst), .search_dir(search_dir), .cmd_ready(cmd_ready),
		.done(done), .presence(presence), .search_fail(search_fail),
		.fast_speed_flag(fast_speed_flag), .io_in(io_line), .io_out(io_out), .io_oe(io_oe),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
	swm_slave_model #(.ROM(ROM_A)) dev_a (.clock(clock), .rst(rst), .enable(en_a),
		.io(io_line), .oe(oe_a), .cmd_seen(cmd_a), .fast_flag(fast_a));
	swm_slave_model #(.ROM(ROM_B)) dev_b (.clock(clock), .rst(rst), .enable(en_b),
		.io(io_line), .oe(oe_b), .cmd_seen(cmd_b), .fast_flag(fast_b));

	// clock
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// collect received bytes
	always @(posedge clock)
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back(rx_data);

	// =====================================================================
	// shared tasks
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic run_op(input swm_pkg::swm_op_t op, input logic lr, input logic [63:0] dir);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 1000)
		begin
			@(negedge clock);
			n++;
		end
		cmd_valid    = 1'b1;
		cmd_op       = op;
		cmd_long_rst = lr;
		search_dir   = dir;
		@(negedge clock);
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 80000)
		begin
			@(negedge clock);
			n++;
		end
		chk(cmd_ready, 1'b1);
	endtask : run_op

	task automatic chk_rom(input logic [63:0] exp);
		repeat (20) @(negedge clock);
		chk(64'(rxq.size()), 64'h8);
		for (int i = 0; i < 8 && i < rxq.size(); i++)
			chk(rxq[i], exp[8*i+:8]);
		rxq.delete();
	endtask : chk_rom

	// =====================================================================
	// scenarios
	task automatic t_power_up();
		int n;
		logic quiet;
		chk(cmd_ready, 1'b0);
		n = 0;
		quiet = 1'b1;
		while (cmd_ready !== 1'b1 && n < 400)
		begin
			@(negedge clock);
			quiet = quiet & (io_oe === 1'b0);
			n++;
		end
		chk(quiet, 1'b1);
		chk(n >= 199 && n <= 201, 1'b1);
	endtask : t_power_up

	task automatic t_overdrive();
		run_op(swm_pkg::OP_OD, 1'b0, 64'h0);
		chk(presence, 1'b1);
		chk(cmd_a, 8'h3C);
		chk(fast_speed_flag, 1'b1);
		chk(fast_a, 1'b1);
		chk(io_oe, 1'b0);
	endtask : t_overdrive

	task automatic t_read();
		en_b     = 1'b0;
		rx_ready = 1'b0;
		run_op(swm_pkg::OP_READ, 1'b0, 64'h0);
		chk(cmd_a, 8'h33);
		chk(fast_a, 1'b1);
		rx_ready = 1'b1;
		chk_rom(ROM_A);
		en_b = 1'b1;
	endtask : t_read

	task automatic t_search();
		run_op(swm_pkg::OP_SEARCH, 1'b0, ROM_B);
		chk(search_fail, 1'b0);
		chk(cmd_b, 8'hF0);
		chk_rom(ROM_B);
	endtask : t_search

	task automatic t_long_reset();
		run_op(swm_pkg::OP_RESET, 1'b1, 64'h0);
		chk(presence, 1'b1);
		chk(fast_speed_flag, 1'b0);
		chk(fast_a, 1'b0);
	endtask : t_long_reset

	task automatic t_absent();
		en_a = 1'b0;
		en_b = 1'b0;
		run_op(swm_pkg::OP_RESET, 1'b0, 64'h0);
		chk(presence, 1'b0);
		chk(64'(rxq.size()), 64'h0);
	endtask : t_absent

	// =====================================================================
	// main sequence
	initial
	begin
		error_cnt    = 0;
		comparisons  = 0;
		rst          = 1'b1;
		cmd_valid    = 1'b0;
		cmd_op       = swm_pkg::OP_RESET;
		cmd_long_rst = 1'b0;
		search_dir   = 64'h0;
		rx_ready     = 1'b1;
		en_a         = 1'b1;
		en_b         = 1'b1;
		repeat (6) @(negedge clock);
		chk(io_oe, 1'b0);
		rst = 1'b0;
		t_power_up();
		t_overdrive();
		t_read();
		t_search();
		t_long_reset();
		t_absent();
		close_out();
	end

	// watchdog
	initial
	begin
		repeat (160000) @(posedge clock);
		error_cnt++;
		close_out();
	end

endmodule : swm_master_bench
